// *** pkg/pipe_notready_defines.svh ***
// register map, reset values and timing constants of the pipe not-ready flag block
`ifndef PIPE_NOTREADY_DEFINES_SVH
`define PIPE_NOTREADY_DEFINES_SVH

// byte addresses of the registers
`define FLAGS_ADDR 12'h068
`define MASK_ADDR 12'h070
`define CTRL_ADDR 12'h074

// register widths and reset values
`define FLAG_COUNT 7
`define FLAGS_WIDTH 16
`define FLAGS_RESET 7'h00
`define MASK_RESET 7'h00
`define CLK_SUPPLY_RESET 1'h1

// field positions
`define FLAG_MSB 6
`define CTRL_CLK_SUPPLY_BIT 0
`define CTRL_SOFT_RESET_BIT 1
`define CTRL_GAP_VIOL_BIT 8

// response-control value selecting buffer-controlled operation
`define PRC_BUF 2'h1

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// least spacing between two clearing writes
`define CLK_PERIOD_NS 40
`define CLEAR_GAP_NS 100
`define CLEAR_GAP_CYC ((`CLEAR_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** pkg/pipe_notready_pkg.sv ***
// types shared by the pipe not-ready flag block
`default_nettype none
package pipe_notready_pkg;

	// which register an address selects
	typedef enum logic [1:0] {
		sel_none,
		sel_flags,
		sel_mask,
		sel_ctrl
	} reg_sel_e;

	typedef logic [1:0] resp_t;

endpackage
`default_nettype wire

// *** logic/notready_event_detect.sv ***
// turns a nak-answered token into a one-cycle set pulse for the matching pipe flag
`timescale 1ns/10ps
`default_nettype none
`include "pipe_notready_defines.svh"

module notready_event_detect #(
	parameter int PIPES = `FLAG_COUNT,
	parameter int PIPE_IDX_W = 3
) (
	input wire logic token_strobe,
	input wire logic [PIPE_IDX_W-1:0] token_pipe,
	input wire logic token_nak,
	input wire logic ctrl_status_stage,
	input wire logic [2*PIPES-1:0] pipe_response_control,
	output logic [PIPES-1:0] set_pulse
);

	// true when a response-control field selects buffer-controlled operation
	function automatic logic is_buf_mode(input logic [1:0] prc);
		is_buf_mode = (prc == `PRC_BUF);
	endfunction

	// one qualifier per pipe; pipe 0 is the default control pipe
	genvar i;
	generate
		for (i = 0; i < PIPES; i++) begin : g_pipe
			logic hit;
			assign hit = token_strobe & token_nak & (token_pipe == PIPE_IDX_W'(i))
				& is_buf_mode(pipe_response_control[2*i +: 2]); // [RULE_04] [RULE_06]
			if (i == 0) begin : g_ctrl
				// a status-stage nak is part of normal control flow, not a stall
				assign set_pulse[i] = hit & ~ctrl_status_stage; // [RULE_10]
			end else begin : g_data
				assign set_pulse[i] = hit; // [RULE_05]
			end
		end
	endgenerate

endmodule
`default_nettype wire

// *** logic/pipe_not_ready_irq_status.sv ***
// pipe not-ready interrupt flag register with axi4-lite slave and masked interrupt
//
// What this block does
// RULE_01 - a 16-bit flag register at 0x68 holds the control pipe flag in bit 0 and data pipes 1 to 6 in bits 1 to 6.
// RULE_02 - hardware and software reset clear the register to zero, and usb bus reset leaves it alone.
// RULE_03 - bits 15 to 7 read as zero and software writes zero to them.
// RULE_04 - a pipe flag sets when an in or out token arrives while that pipe's buffer is not ready.
// RULE_05 - bits 6 to 1 belong to data pipes 6 to 1, bit 0 to the control pipe, and a one means the event happened.
// RULE_06 - not ready means a nak went out with transfers disabled while the pipe was in buffer-controlled mode.
// RULE_07 - writing zero to a flag bit clears that flag.
// RULE_08 - writing one to a flag bit leaves that flag unchanged.
// RULE_09 - while the internal clock supply is off, writing zero clears no flag.
// RULE_10 - a nak in the status stage of a control transfer does not set the control pipe flag.
// RULE_11 - software spaces successive clearing writes at least 100 ns apart, or clears several flags in one write.
// RULE_12 - a set arriving in the same cycle as a clear of the same flag wins.
`timescale 1ns/10ps
`default_nettype none
`include "pipe_notready_defines.svh"

module pipe_not_ready_irq_status #(
	parameter int ADDR_W = 12,
	parameter int PIPE_IDX_W = 3,
	parameter int GAP_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic token_strobe,
	input wire logic [PIPE_IDX_W-1:0] token_pipe,
	input wire logic token_nak,
	input wire logic ctrl_status_stage,
	input wire logic [2*`FLAG_COUNT-1:0] pipe_response_control,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic irq_ff;

	logic aw_held_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic w_held_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;

	logic [`FLAG_COUNT-1:0] flags_ff;
	logic [`FLAG_COUNT-1:0] nxt_flags;
	logic [`FLAG_COUNT-1:0] mask_ff;
	logic clk_supply_ff;
	logic gap_viol_ff;
	logic [GAP_W-1:0] gap_cnt_ff;

	logic [`FLAG_COUNT-1:0] set_pulse;
	logic [`FLAG_COUNT-1:0] clr_bits;
	logic wr_fire;
	logic ar_fire;
	pipe_notready_pkg::reg_sel_e wr_sel;
	pipe_notready_pkg::reg_sel_e rd_sel;
	logic wr_flags;
	logic wr_mask;
	logic wr_ctrl;
	logic soft_reset;
	logic clearing_write;
	logic rd_ctrl;

	////////////////////////////////////////////////////////////////////////////
	// address decode, shared by the write and read paths

	// word-aligned: the two low address bits are ignored
	function automatic pipe_notready_pkg::reg_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = {addr[ADDR_W-1:2], 2'h0};
		if (word == ADDR_W'(`FLAGS_ADDR)) begin
			decode_reg = pipe_notready_pkg::sel_flags; // [RULE_01]
		end else if (word == ADDR_W'(`MASK_ADDR)) begin
			decode_reg = pipe_notready_pkg::sel_mask;
		end else if (word == ADDR_W'(`CTRL_ADDR)) begin
			decode_reg = pipe_notready_pkg::sel_ctrl;
		end else begin
			decode_reg = pipe_notready_pkg::sel_none;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// event qualification

	notready_event_detect #(
		.PIPES(`FLAG_COUNT),
		.PIPE_IDX_W(PIPE_IDX_W)
	) u_detect (
		.token_strobe(token_strobe),
		.token_pipe(token_pipe),
		.token_nak(token_nak),
		.ctrl_status_stage(ctrl_status_stage),
		.pipe_response_control(pipe_response_control),
		.set_pulse(set_pulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// axi write channels

	// address and data are taken independently and held until the response goes
	always_ff @(posedge clk) begin
		if (rst) begin
			awready_ff <= 1'h1;
			aw_held_ff <= 1'h0;
			aw_addr_ff <= '0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'h0;
			aw_held_ff <= 1'h1;
			aw_addr_ff <= awaddr;
		end else if (bvalid_ff && bready) begin
			awready_ff <= 1'h1;
			aw_held_ff <= 1'h0;
		end
	end

	// write data slot
	always_ff @(posedge clk) begin
		if (rst) begin
			wready_ff <= 1'h1;
			w_held_ff <= 1'h0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'h0;
			w_held_ff <= 1'h1;
			w_data_ff <= wdata;
			w_strb_ff <= wstrb;
		end else if (bvalid_ff && bready) begin
			wready_ff <= 1'h1;
			w_held_ff <= 1'h0;
		end
	end

	// the write commits once, in the cycle both halves are present
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign wr_sel = decode_reg(aw_addr_ff);
	assign wr_flags = wr_fire & (wr_sel == pipe_notready_pkg::sel_flags) & w_strb_ff[0];
	assign wr_mask = wr_fire & (wr_sel == pipe_notready_pkg::sel_mask) & w_strb_ff[0];
	assign wr_ctrl = wr_fire & (wr_sel == pipe_notready_pkg::sel_ctrl) & w_strb_ff[0];
	assign soft_reset = wr_ctrl & w_data_ff[`CTRL_SOFT_RESET_BIT];

	// write response; unmapped addresses answer slverr and change nothing
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_ff <= 1'h0;
			bresp_ff <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'h1;
			bresp_ff <= (wr_sel == pipe_notready_pkg::sel_none) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (bvalid_ff && bready) begin
			bvalid_ff <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flag register

	// zeros clear, ones are ignored, and a stopped internal clock blocks clearing;
	// the upper byte lane holds only reserved bits so its data are dropped
	assign clr_bits = (wr_flags && clk_supply_ff) ? ~w_data_ff[`FLAG_MSB:0] : '0; // [RULE_07] [RULE_08] [RULE_09] [RULE_03]

	// set is or-ed in after the clear, so a simultaneous event survives
	assign nxt_flags = (flags_ff & ~clr_bits) | set_pulse; // [RULE_12] [RULE_04]

	// usb bus reset has no input here: only the two resets touch the flags
	always_ff @(posedge clk) begin
		if (rst || soft_reset) begin
			flags_ff <= `FLAGS_RESET; // [RULE_02]
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mask and control registers

	// interrupt mask, same layout as the flags
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_ff <= `MASK_RESET;
		end else if (wr_mask) begin
			mask_ff <= w_data_ff[`FLAG_MSB:0];
		end
	end

	// internal clock supply control; soft reset bit is a strobe and is not stored
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_supply_ff <= `CLK_SUPPLY_RESET;
		end else if (wr_ctrl) begin
			clk_supply_ff <= w_data_ff[`CTRL_CLK_SUPPLY_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clearing-write spacing monitor

	// a clear that really removes bits counts as a clearing write
	assign clearing_write = wr_flags & clk_supply_ff & (|(flags_ff & ~w_data_ff[`FLAG_MSB:0]));

	// counts down the least spacing after each clearing write
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_cnt_ff <= '0;
		end else if (clearing_write) begin
			gap_cnt_ff <= GAP_W'(`CLEAR_GAP_CYC - 1);
		end else if (gap_cnt_ff != '0) begin
			gap_cnt_ff <= gap_cnt_ff - GAP_W'(1);
		end
	end

	// sticky; a read of the control register clears it, a new violation wins
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_viol_ff <= 1'h0;
		end else if (clearing_write && gap_cnt_ff != '0) begin
			gap_viol_ff <= 1'h1; // [RULE_11]
		end else if (rd_ctrl) begin
			gap_viol_ff <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi read channel

	assign ar_fire = arvalid & arready_ff;
	assign rd_sel = decode_reg(araddr);
	assign rd_ctrl = ar_fire & (rd_sel == pipe_notready_pkg::sel_ctrl);

	// one read at a time: arready drops until the data are taken
	always_ff @(posedge clk) begin
		if (rst) begin
			arready_ff <= 1'h1;
			rvalid_ff <= 1'h0;
		end else if (ar_fire) begin
			arready_ff <= 1'h0;
			rvalid_ff <= 1'h1;
		end else if (rvalid_ff && rready) begin
			arready_ff <= 1'h1;
			rvalid_ff <= 1'h0;
		end
	end

	// read data captured at the address handshake; reserved bits are zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= '0;
			rresp_ff <= `RESP_OKAY;
		end else if (ar_fire) begin
			rdata_ff <= '0;
			rresp_ff <= `RESP_OKAY;
			unique case (rd_sel)
				pipe_notready_pkg::sel_flags: begin
					rdata_ff[`FLAG_MSB:0] <= flags_ff; // [RULE_03] [RULE_05]
				end
				pipe_notready_pkg::sel_mask: begin
					rdata_ff[`FLAG_MSB:0] <= mask_ff;
				end
				pipe_notready_pkg::sel_ctrl: begin
					rdata_ff[`CTRL_CLK_SUPPLY_BIT] <= clk_supply_ff;
					rdata_ff[`CTRL_GAP_VIOL_BIT] <= gap_viol_ff;
				end
				pipe_notready_pkg::sel_none: begin
					rresp_ff <= `RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt output

	// level output, one cycle behind the flags so it leaves a flip-flop
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'h0;
		end else begin
			irq_ff <= |(flags_ff & mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign irq = irq_ff;

endmodule
`default_nettype wire

// *** tb/pipe_notready_assertions.sv ***
// port-level assertions for the pipe not-ready flag block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module pipe_notready_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic token_strobe,
	input wire logic token_nak,
	input wire logic irq
);
	// one clock domain, so clocking and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// bus answers: fixed latency, never without a request
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	read_cause_a: assert property ($rose(rvalid) |-> $past(arvalid && arready))
		else $error("read answer without request");
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	write_cause_a: assert property ($rose(bvalid) |->
		$past(awvalid && awready, 2) || $past(wvalid && wready, 2)) else $error("write answer without request");
	write_stall_a: assert property (bvalid |-> !awready && !wready)
		else $error("second write taken while one outstanding");
	// upper bits of every readable word are zero
	reserved_zero_a: assert property (rvalid |-> rdata[31:9] == 23'h0)
		else $error("reserved read bits set");
	// irq rises only after a nak event or a register commit, and falls only after a register commit or a reset
	irq_rise_a: assert property ($rose(irq) |-> $past(token_strobe && token_nak, 2) || $past(bvalid))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(bvalid) || $past(rst))
		else $error("irq fell without cause");
endmodule
bind pipe_not_ready_irq_status pipe_notready_checker checker_i (.clk, .rst, .awvalid, .awready, .wvalid, .wready,
	.bvalid, .arvalid, .arready, .rdata, .rvalid, .token_strobe, .token_nak, .irq);
`default_nettype wire

// *** tb/usb_host_model.sv ***
// behavioural usb host: issues in/out tokens and sets pipe modes
`timescale 1ns/10ps
`default_nettype none
`include "pipe_notready_defines.svh"
module usb_host_model (
	input wire logic clk,
	output logic token_strobe,
	output logic [2:0] token_pipe,
	output logic token_nak,
	output logic ctrl_status_stage,
	output logic [13:0] pipe_response_control
);
	// idle: no token, every pipe in buffer-controlled mode
	initial begin
		token_strobe = 1'h0;
		token_pipe = 3'h0;
		token_nak = 1'h0;
		ctrl_status_stage = 1'h0;
		pipe_response_control = {7{`PRC_BUF}};
	end
	// one-cycle token; pipe and nak flip after it so stale values never look valid
	task automatic token(input logic [2:0] p, input logic nak, input logic stat);
		@(posedge clk);
		token_strobe <= 1'h1;
		token_pipe <= p;
		token_nak <= nak;
		ctrl_status_stage <= stat;
		@(posedge clk);
		token_strobe <= 1'h0;
		token_pipe <= ~p;
		token_nak <= ~nak;
	endtask
	// response-control fields of all pipes
	task automatic set_mode(input logic [13:0] m);
		@(posedge clk);
		pipe_response_control <= m;
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the pipe not-ready flag block
`timescale 1ns/10ps
`default_nettype none
`include "pipe_notready_defines.svh"
module testbench;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
	logic token_strobe, token_nak, ctrl_status_stage;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, e;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] token_pipe;
	logic [13:0] pipe_response_control;
	int fails = 0;
	int checks = 0;
	pipe_not_ready_irq_status pipe_not_ready_irq_status_i (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.token_strobe, .token_pipe, .token_nak, .ctrl_status_stage, .pipe_response_control, .irq);
	usb_host_model usb_host_model_i (.clk, .token_strobe, .token_pipe, .token_nak, .ctrl_status_stage,
		.pipe_response_control);
	////////////////////////////////////////////////////////////
	// 25 mhz clock
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// axi4-lite write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// axi4-lite read with data and response compare
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// irq lags the registers by one cycle, so look one edge later
	task automatic irq_is(input logic v);
		@(posedge clk);
		chk({31'h0, irq}, {31'h0, v});
	endtask
	task automatic end_sim;
		$display("fails=%0d checks=%0d", fails, checks);
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_sim;
	end
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(`FLAGS_ADDR, 32'h0, `RESP_OKAY);
		rd(`MASK_ADDR, 32'h0, `RESP_OKAY);
		rd(`CTRL_ADDR, 32'h1, `RESP_OKAY);
		irq_is(1'h0);
		e = 32'h0;
		for (int p = 0; p < 7; p++) begin
			usb_host_model_i.token(p[2:0], 1'h1, 1'h0);
			e[p] = 1'h1;
			rd(`FLAGS_ADDR, e, `RESP_OKAY);
		end
		wr(`FLAGS_ADDR, 32'h7f, `RESP_OKAY);
		rd(`FLAGS_ADDR, 32'h7f, `RESP_OKAY);
		wr(`FLAGS_ADDR, 32'h79, `RESP_OKAY);
		wr(`FLAGS_ADDR, 32'h78, `RESP_OKAY);
		rd(`FLAGS_ADDR, 32'h78, `RESP_OKAY);
		// spaced clears leave the spacing monitor quiet
		rd(`CTRL_ADDR, 32'h1, `RESP_OKAY);
		// tokens that must leave every flag alone
		usb_host_model_i.token(3'h1, 1'h0, 1'h0);
		usb_host_model_i.token(3'h0, 1'h1, 1'h1);
		usb_host_model_i.set_mode(14'h1545);
		usb_host_model_i.token(3'h2, 1'h1, 1'h0);
		usb_host_model_i.set_mode(14'h1555);
		rd(`FLAGS_ADDR, 32'h78, `RESP_OKAY);
		// mask gates the interrupt; clearing the flag drops it
		wr(`MASK_ADDR, 32'h8, `RESP_OKAY);
		irq_is(1'h1);
		wr(`MASK_ADDR, 32'h0, `RESP_OKAY);
		irq_is(1'h0);
		wr(`MASK_ADDR, 32'h8, `RESP_OKAY);
		wr(`FLAGS_ADDR, 32'h77, `RESP_OKAY);
		irq_is(1'h0);
		// internal clock stopped: clearing has no effect
		wr(`CTRL_ADDR, 32'h0, `RESP_OKAY);
		wr(`FLAGS_ADDR, 32'h0, `RESP_OKAY);
		rd(`FLAGS_ADDR, 32'h70, `RESP_OKAY);
		wr(`CTRL_ADDR, 32'h1, `RESP_OKAY);
		// without the low byte lane a zero write clears nothing
		wstrb <= 4'he;
		wr(`FLAGS_ADDR, 32'h0, `RESP_OKAY);
		wstrb <= 4'hf;
		rd(`FLAGS_ADDR, 32'h70, `RESP_OKAY);
		// set lands on the commit edge of a clear of the same flag
		fork
			wr(`FLAGS_ADDR, 32'h6f, `RESP_OKAY);
			begin
				@(posedge clk);
				usb_host_model_i.token(3'h4, 1'h1, 1'h0);
			end
		join
		rd(`FLAGS_ADDR, 32'h70, `RESP_OKAY);
		wr(12'h040, 32'h0, `RESP_SLVERR);
		rd(12'h040, 32'h0, `RESP_SLVERR);
		wr(`CTRL_ADDR, 32'h3, `RESP_OKAY);
		rd(`FLAGS_ADDR, 32'h0, `RESP_OKAY);
		end_sim;
	end
endmodule
`default_nettype wire
